/* File: verilog/ext_bus_ctrl_pkg.sv */
/*
 * Constants and types shared by the external bus controller files.
 * Assumes a single clock domain and a synchronous active-high reset.
 */
`default_nettype none

package ext_bus_ctrl_pkg;

	// ***************************************************
	// Widths and counts
	// ***************************************************
	localparam int ADDR_W = 24;
	localparam int DATA_W = 16;
	localparam int NUM_WIN = 4;
	localparam int NUM_REG = 5;
	localparam int TCFG_W = 4;
	localparam int FCFG_W = 4;
	localparam int WSEL_W = 16;
	localparam int WBASE_W = 12;
	localparam int WSIZE_W = 4;
	localparam int SEG_W = 3;
	localparam int AW_W = 5;

	// ***************************************************
	// Field positions
	// ***************************************************
	localparam int FCFG_WIDTH16 = 0;
	localparam int FCFG_MUX = 1;
	localparam int FCFG_READY = 2;
	localparam int FCFG_CS = 3;
	localparam int WSEL_SIZE_LSB = 0;
	localparam int WSEL_BASE_LSB = 4;
	localparam int WIN_GRAIN_LSB = 12;
	localparam int SEG_LSB = 16;

	// ***************************************************
	// Timing and reset values
	// ***************************************************
	localparam int CLK_MHZ = 200;
	localparam int BUS_CLK_MHZ = 50;
	localparam int BUS_HALF_CYCLES = CLK_MHZ / BUS_CLK_MHZ / 2;
	localparam logic [AW_W-1:0] SEG_BASE_W = 5'h10;
	localparam logic [7:0] IPB_SEGMENT = 8'h20;
	localparam logic [NUM_REG-1:0] CS_IDLE = 5'h1f;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_CMD,
		ST_END,
		ST_IPB
	} bus_state_t;

endpackage

`default_nettype wire

/* File: verilog/sync_two_flop.sv */
/*
 * Two-flop synchroniser for pin inputs.
 * Assumes inputs are asynchronous to clk; output lags by two edges.
 */
`timescale 1ns/100ps
`default_nettype none

module sync_two_flop #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);

	logic [W-1:0] stage1;

	always_ff @(posedge clk) begin
		if (reset) begin
			stage1 <= '0;
			dout <= '0;
		end else begin
			stage1 <= din;
			dout <= stage1;
		end
	end

endmodule

`default_nettype wire

/* File: verilog/window_match.sv */
/*
 * Address window comparator: base plus power-of-two size.
 * Assumes size code 0 means 4 Kbytes, each step doubles it up to code 12.
 */
`timescale 1ns/100ps
`default_nettype none

module window_match (
	input wire logic [ext_bus_ctrl_pkg::ADDR_W-1:0] addr,
	input wire logic [ext_bus_ctrl_pkg::WSEL_W-1:0] selCfg,
	input wire logic enable,
	output logic hit
);

	logic [ext_bus_ctrl_pkg::WBASE_W-1:0] base;
	logic [ext_bus_ctrl_pkg::WSIZE_W-1:0] sizeCode;
	logic [ext_bus_ctrl_pkg::WBASE_W-1:0] lowMask;
	logic [ext_bus_ctrl_pkg::WBASE_W-1:0] upper;

	assign base = selCfg[ext_bus_ctrl_pkg::WSEL_BASE_LSB +:
		ext_bus_ctrl_pkg::WBASE_W];
	assign sizeCode = selCfg[ext_bus_ctrl_pkg::WSEL_SIZE_LSB +:
		ext_bus_ctrl_pkg::WSIZE_W];
	assign upper = addr[ext_bus_ctrl_pkg::WIN_GRAIN_LSB +:
		ext_bus_ctrl_pkg::WBASE_W];
	assign lowMask = 12'((16'h1 << sizeCode) - 16'h1);
	assign hit = enable && ((upper & ~lowMask) == (base & ~lowMask));

endmodule

`default_nettype wire

/* File: verilog/ext_bus_ctrl.sv */
/*
 * External bus controller: runs CPU-side requests out to the external
 * address/data bus or to the internal peripheral bus.
 * Assumes one clk domain; ready and data pins are asynchronous inputs.
 */
// Summary of operation
// - Every external access, and every internal peripheral access, runs here.
// - Single-chip mode blocks external activity; otherwise a bus mode is used.
// - The driven address width is configurable from 0 to 23 bits.
// - Each region selects an 8-bit or 16-bit data bus.
// - Each region selects multiplexed or demultiplexed operation.
// - Demultiplexed accesses drive the low address on dedicated lines.
// - Segment line count limits space to 64K..8M; unused lines are freed.
// - One chip select per window plus one for the default region.
// - Timing and function settings are programmed per region.
// - A ready input of selectable level stretches an access.
// - Up to four programmable address windows are decoded.
// - On overlap window 4 beats 3 and window 2 beats 1.
// - Addresses outside all windows use the region-zero settings.
// - Only the selected region may assert its chip select.
// - Bus timing follows the rising edge of the reference clock output.
// - Bus width and multiplexing switch per access by region.
`timescale 1ns/100ps
`default_nettype none

module ext_bus_ctrl (
	input wire logic clk,
	input wire logic reset,
	// Request side
	input wire logic reqValid,
	output logic reqReady,
	input wire logic [ext_bus_ctrl_pkg::ADDR_W-1:0] reqAddr,
	input wire logic reqWrite,
	input wire logic reqWord,
	input wire logic [ext_bus_ctrl_pkg::DATA_W-1:0] reqWdata,
	output logic rspValid,
	output logic rspError,
	output logic [ext_bus_ctrl_pkg::DATA_W-1:0] rspRdata,
	// Configuration
	input wire logic singleChip,
	input wire logic [ext_bus_ctrl_pkg::AW_W-1:0] addrWidth,
	input wire logic [ext_bus_ctrl_pkg::SEG_W-1:0] segLines,
	input wire logic readyActiveHigh,
	input wire logic [ext_bus_ctrl_pkg::NUM_WIN-1:0] windowEnable,
	input wire logic [ext_bus_ctrl_pkg::NUM_WIN*ext_bus_ctrl_pkg::WSEL_W-1:0]
		window_select_cfg,
	input wire logic [ext_bus_ctrl_pkg::NUM_REG*ext_bus_ctrl_pkg::TCFG_W-1:0]
		region_timing_cfg,
	input wire logic [ext_bus_ctrl_pkg::NUM_REG*ext_bus_ctrl_pkg::FCFG_W-1:0]
		region_function_cfg,
	// External bus pins
	output logic bus_ref_clock_out,
	output logic [ext_bus_ctrl_pkg::ADDR_W-1:0] addrOut,
	output logic [ext_bus_ctrl_pkg::ADDR_W-1:0] addrOe,
	output logic [ext_bus_ctrl_pkg::DATA_W-1:0] adBusOut,
	output logic adBusOe,
	input wire logic [ext_bus_ctrl_pkg::DATA_W-1:0] adBusIn,
	output logic aleOut,
	output logic rdN,
	output logic wrN,
	output logic [ext_bus_ctrl_pkg::NUM_REG-1:0] csN,
	input wire logic readyPin,
	// Internal peripheral bus
	output logic ipbReq,
	output logic ipbWrite,
	output logic [ext_bus_ctrl_pkg::ADDR_W-1:0] ipbAddr,
	output logic [ext_bus_ctrl_pkg::DATA_W-1:0] ipbWdata,
	input wire logic ipbAck,
	input wire logic [ext_bus_ctrl_pkg::DATA_W-1:0] ipbRdata
);

	// ***************************************************
	// Pin synchronisers
	// ***************************************************
	logic readySync;
	logic [ext_bus_ctrl_pkg::DATA_W-1:0] adInSync;

	sync_two_flop #(.W(1)) u_sync_ready (
		.clk(clk),
		.reset(reset),
		.din(readyPin),
		.dout(readySync)
	);

	sync_two_flop #(.W(ext_bus_ctrl_pkg::DATA_W)) u_sync_data (
		.clk(clk),
		.reset(reset),
		.din(adBusIn),
		.dout(adInSync)
	);

	// ***************************************************
	// Reference clock divider
	// ***************************************************
	logic [3:0] divCnt;
	logic busTick;
	logic divWrap;

	assign divWrap = (divCnt == 4'(ext_bus_ctrl_pkg::BUS_HALF_CYCLES - 1));

	always_ff @(posedge clk) begin
		if (reset) begin
			divCnt <= 4'h0;
			bus_ref_clock_out <= 1'b0;
			busTick <= 1'b0;
		end else begin
			divCnt <= divWrap ? 4'h0 : divCnt + 4'h1;
			if (divWrap)
				bus_ref_clock_out <= ~bus_ref_clock_out;
			busTick <= divWrap && !bus_ref_clock_out;
		end
	end

	// ***************************************************
	// Window decode
	// ***************************************************
	logic [ext_bus_ctrl_pkg::NUM_WIN-1:0] winHit;
	logic [2:0] region;
	logic isIpb;

	genvar gi;
	generate
		for (gi = 0; gi < ext_bus_ctrl_pkg::NUM_WIN; gi++) begin : g_win
			window_match u_win (
				.addr(reqAddr),
				.selCfg(window_select_cfg[gi*ext_bus_ctrl_pkg::WSEL_W +:
					ext_bus_ctrl_pkg::WSEL_W]),
				.enable(windowEnable[gi]),
				.hit(winHit[gi])
			);
		end
	endgenerate

	// Fixed chain 4 > 3 > 2 > 1, else default region 0
	assign region = winHit[3] ? 3'h4 :
		winHit[2] ? 3'h3 :
		winHit[1] ? 3'h2 :
		winHit[0] ? 3'h1 : 3'h0;
	assign isIpb = (reqAddr[ext_bus_ctrl_pkg::ADDR_W-1 -: 8] ==
		ext_bus_ctrl_pkg::IPB_SEGMENT);

	logic [ext_bus_ctrl_pkg::TCFG_W-1:0] selTcfg;
	logic [ext_bus_ctrl_pkg::FCFG_W-1:0] selFcfg;

	assign selTcfg = region_timing_cfg[region*ext_bus_ctrl_pkg::TCFG_W +:
		ext_bus_ctrl_pkg::TCFG_W];
	assign selFcfg = region_function_cfg[region*ext_bus_ctrl_pkg::FCFG_W +:
		ext_bus_ctrl_pkg::FCFG_W];

	// ***************************************************
	// Address width limits
	// ***************************************************
	logic [ext_bus_ctrl_pkg::AW_W-1:0] segLimit;
	logic [ext_bus_ctrl_pkg::AW_W-1:0] effWidth;
	logic [ext_bus_ctrl_pkg::ADDR_W-1:0] widthMask;

	assign segLimit = ext_bus_ctrl_pkg::SEG_BASE_W + {2'h0, segLines};
	assign effWidth = (addrWidth < segLimit) ? addrWidth : segLimit;
	assign widthMask = 24'((25'h1 << effWidth) - 25'h1);

	// ***************************************************
	// Access sequencer
	// ***************************************************
	ext_bus_ctrl_pkg::bus_state_t state;
	logic [ext_bus_ctrl_pkg::ADDR_W-1:0] curAddr;
	logic [ext_bus_ctrl_pkg::DATA_W-1:0] curWdata;
	logic [ext_bus_ctrl_pkg::DATA_W-1:0] rdBuf;
	logic [2:0] curRegion;
	logic [ext_bus_ctrl_pkg::TCFG_W-1:0] curWaits;
	logic [ext_bus_ctrl_pkg::TCFG_W-1:0] waitCnt;
	logic curWrite;
	logic curWord;
	logic curWide;
	logic curMux;
	logic curReadyEn;
	logic curCsEn;
	logic beat;

	logic accept;
	logic readyOk;
	logic waitDone;
	logic needSecond;
	logic [ext_bus_ctrl_pkg::DATA_W-1:0] beatData;
	logic [ext_bus_ctrl_pkg::DATA_W-1:0] next_rdBuf;
	logic [ext_bus_ctrl_pkg::ADDR_W-1:0] driveMask;
	logic [ext_bus_ctrl_pkg::NUM_REG-1:0] csSel;

	assign accept = reqValid && reqReady;
	assign readyOk = !curReadyEn || (readySync == readyActiveHigh);
	assign waitDone = (waitCnt == '0) && readyOk;
	assign needSecond = !curWide && curWord && !beat;
	// Eight-bit bus carries low byte first, then high byte
	assign beatData = curWide ? curWdata :
		(beat ? {8'h00, curWdata[15:8]} : {8'h00, curWdata[7:0]});
	assign next_rdBuf = curWide ? adInSync :
		(beat ? {adInSync[7:0], rdBuf[7:0]} : {8'h00, adInSync[7:0]});
	// Multiplexed mode frees the dedicated low lines
	assign driveMask = curMux ? (widthMask & 24'hff0000) : widthMask;
	assign csSel = curCsEn ? ~(5'(5'h1 << curRegion)) :
		ext_bus_ctrl_pkg::CS_IDLE;

	// Settings latched only on acceptance, i.e. between accesses
	always_ff @(posedge clk) begin
		if (reset) begin
			curAddr <= '0;
			curWdata <= '0;
			curRegion <= 3'h0;
			curWaits <= '0;
			curWrite <= 1'b0;
			curWord <= 1'b0;
			curWide <= 1'b0;
			curMux <= 1'b0;
			curReadyEn <= 1'b0;
			curCsEn <= 1'b0;
		end else if (accept) begin
			curAddr <= reqAddr;
			curWdata <= reqWdata;
			curRegion <= region;
			curWaits <= selTcfg;
			curWrite <= reqWrite;
			curWord <= reqWord;
			curWide <= selFcfg[ext_bus_ctrl_pkg::FCFG_WIDTH16];
			curMux <= selFcfg[ext_bus_ctrl_pkg::FCFG_MUX];
			curReadyEn <= selFcfg[ext_bus_ctrl_pkg::FCFG_READY];
			curCsEn <= selFcfg[ext_bus_ctrl_pkg::FCFG_CS];
		end else if (state == ext_bus_ctrl_pkg::ST_END && busTick &&
			needSecond) begin
			curAddr <= curAddr + 24'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state <= ext_bus_ctrl_pkg::ST_IDLE;
			reqReady <= 1'b1;
			rspValid <= 1'b0;
			rspError <= 1'b0;
			rspRdata <= '0;
			rdBuf <= '0;
			waitCnt <= '0;
			beat <= 1'b0;
		end else begin
			rspValid <= 1'b0;
			unique case (state)
			ext_bus_ctrl_pkg::ST_IDLE: begin
				beat <= 1'b0;
				if (accept) begin
					reqReady <= 1'b0;
					if (isIpb) begin
						state <= ext_bus_ctrl_pkg::ST_IPB;
					end else if (singleChip) begin
						rspValid <= 1'b1;
						rspError <= 1'b1;
						rspRdata <= '0;
						reqReady <= 1'b1;
					end else begin
						state <= ext_bus_ctrl_pkg::ST_ADDR;
					end
				end
			end
			ext_bus_ctrl_pkg::ST_ADDR: begin
				if (busTick) begin
					waitCnt <= curWaits;
					state <= ext_bus_ctrl_pkg::ST_CMD;
				end
			end
			ext_bus_ctrl_pkg::ST_CMD: begin
				// First tick only raises the strobe; data comes later
				if (busTick && !(rdN && wrN)) begin
					if (waitCnt != '0)
						waitCnt <= waitCnt - 4'h1;
					else if (waitDone) begin
						if (!curWrite)
							rdBuf <= next_rdBuf;
						state <= ext_bus_ctrl_pkg::ST_END;
					end
				end
			end
			ext_bus_ctrl_pkg::ST_END: begin
				if (busTick) begin
					if (needSecond) begin
						beat <= 1'b1;
						state <= ext_bus_ctrl_pkg::ST_ADDR;
					end else begin
						rspValid <= 1'b1;
						rspError <= 1'b0;
						rspRdata <= rdBuf;
						reqReady <= 1'b1;
						state <= ext_bus_ctrl_pkg::ST_IDLE;
					end
				end
			end
			ext_bus_ctrl_pkg::ST_IPB: begin
				if (ipbAck) begin
					rspValid <= 1'b1;
					rspError <= 1'b0;
					rspRdata <= curWrite ? '0 : ipbRdata;
					reqReady <= 1'b1;
					state <= ext_bus_ctrl_pkg::ST_IDLE;
				end
			end
			endcase
		end
	end

	// ***************************************************
	// Pin drivers, updated at reference clock rise
	// ***************************************************
	logic inAddr;
	logic inCmd;
	logic inEnd;

	assign inAddr = (state == ext_bus_ctrl_pkg::ST_ADDR);
	assign inCmd = (state == ext_bus_ctrl_pkg::ST_CMD);
	assign inEnd = (state == ext_bus_ctrl_pkg::ST_END);

	always_ff @(posedge clk) begin
		if (reset) begin
			addrOut <= '0;
			addrOe <= '0;
			adBusOut <= '0;
			adBusOe <= 1'b0;
			aleOut <= 1'b0;
			rdN <= 1'b1;
			wrN <= 1'b1;
			csN <= ext_bus_ctrl_pkg::CS_IDLE;
		end else if (busTick) begin
			if (inAddr) begin
				addrOut <= curAddr & driveMask;
				addrOe <= driveMask;
				csN <= csSel;
				aleOut <= curMux;
				adBusOut <= curMux ? 16'(curAddr & widthMask) : '0;
				adBusOe <= curMux;
			end else if (inCmd && waitCnt == curWaits && !aleOut &&
				rdN && wrN) begin
				rdN <= curWrite;
				wrN <= !curWrite;
				adBusOut <= curWrite ? beatData : '0;
				adBusOe <= curWrite;
			end else if (inCmd && aleOut) begin
				aleOut <= 1'b0;
				rdN <= curWrite;
				wrN <= !curWrite;
				adBusOut <= curWrite ? beatData : '0;
				adBusOe <= curWrite;
			end else if (inEnd || state == ext_bus_ctrl_pkg::ST_IDLE) begin
				rdN <= 1'b1;
				wrN <= 1'b1;
				adBusOe <= 1'b0;
				csN <= ext_bus_ctrl_pkg::CS_IDLE;
				if (!needSecond)
					addrOe <= '0;
			end
		end
	end

	// ***************************************************
	// Internal peripheral bus
	// ***************************************************
	always_ff @(posedge clk) begin
		if (reset) begin
			ipbReq <= 1'b0;
			ipbWrite <= 1'b0;
			ipbAddr <= '0;
			ipbWdata <= '0;
		end else if (accept && isIpb) begin
			ipbReq <= 1'b1;
			ipbWrite <= reqWrite;
			ipbAddr <= reqAddr;
			ipbWdata <= reqWdata;
		end else if (ipbAck) begin
			ipbReq <= 1'b0;
		end
	end

endmodule

`default_nettype wire

/* File: test/ext_bus_ctrl_assertions.sv */
/*
 * Checker on the top ports of the external bus controller.
 * Assumes one clk domain; bound to the design at the foot of this file.
 */
`timescale 1ns/100ps
`default_nettype none

module ext_bus_ctrl_assertions (
	input wire logic clk,
	input wire logic reset,
	input wire logic reqReady,
	input wire logic rspValid,
	input wire logic rspError,
	input wire logic singleChip,
	input wire logic bus_ref_clock_out,
	input wire logic adBusOe,
	input wire logic aleOut,
	input wire logic rdN,
	input wire logic wrN,
	input wire logic [ext_bus_ctrl_pkg::NUM_REG-1:0] csN,
	input wire logic ipbReq,
	input wire logic ipbAck
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	// ****************
	// Properties
	// ****************
	chk_cs_single: assert property ($onehot0(~csN))
		else $error("two chip selects low");
	chk_ref_period: assert property ($rose(bus_ref_clock_out) |->
		bus_ref_clock_out ##1 bus_ref_clock_out ##1 !bus_ref_clock_out
		##1 !bus_ref_clock_out ##1 bus_ref_clock_out)
		else $error("reference clock period wrong");
	chk_pins_rise: assert property (
		$changed({rdN, wrN, csN, aleOut}) |->
		$past(bus_ref_clock_out) && !$past(bus_ref_clock_out, 2))
		else $error("bus pin moved off reference edge");
	chk_chip_quiet: assert property (
		singleChip && reqReady |-> &csN && rdN && wrN)
		else $error("bus active in single chip mode");
	chk_err_chip: assert property (rspValid && rspError |-> singleChip)
		else $error("error response outside single chip mode");
	chk_ipb_quiet: assert property (ipbReq |-> &csN && rdN && wrN)
		else $error("external bus active on peripheral access");
	chk_ipb_hold: assert property (ipbReq && !ipbAck |=> ipbReq)
		else $error("peripheral request dropped early");
	chk_ale_addr: assert property (aleOut |-> adBusOe && rdN && wrN)
		else $error("address phase wrong");
	chk_read_free: assert property (!rdN |-> !adBusOe)
		else $error("shared lines driven during read");
	chk_write_drive: assert property (!wrN |-> adBusOe)
		else $error("write data not driven");
	chk_strobe_width: assert property ($fell(rdN) |-> !rdN [*4])
		else $error("read strobe too short");
endmodule

bind ext_bus_ctrl ext_bus_ctrl_assertions chk_u (.clk, .reset, .reqReady,
	.rspValid, .rspError, .singleChip, .bus_ref_clock_out, .adBusOe,
	.aleOut, .rdN, .wrN, .csN, .ipbReq, .ipbAck);

`default_nettype wire

/* File: test/ext_mem_model.sv */
/*
 * Far side model: external memory with ready pin, peripheral responder.
 * Assumes its pins are sampled on the controller's clk.
 */
`timescale 1ns/100ps
`default_nettype none

module ext_mem_model (
	input wire logic clk,
	input wire logic readyActiveHigh,
	input wire logic [7:0] rdyDelay,
	input wire logic [23:0] addrOut,
	input wire logic [23:0] addrOe,
	input wire logic [15:0] adBusOut,
	input wire logic aleOut,
	input wire logic rdN,
	input wire logic wrN,
	input wire logic [4:0] csN,
	input wire logic ipbReq,
	input wire logic [23:0] ipbAddr,
	output logic [15:0] adBusIn,
	output logic readyPin,
	output logic ipbAck,
	output logic [15:0] ipbRdata,
	output logic [23:0] lastOe,
	output logic [4:0] lastCs,
	output logic [15:0] wrData
);
	logic [23:0] lat;
	logic [7:0] cnt;
	logic prevRd;
	wire strobe = !rdN || !wrN;

	// Ready after a programmable stretch
	assign readyPin = (strobe && cnt >= rdyDelay) ? readyActiveHigh :
		!readyActiveHigh;

	initial begin
		adBusIn = 16'h0;
		ipbAck = 1'b0;
		ipbRdata = 16'h0;
		cnt = 8'h0;
		prevRd = 1'b1;
	end

	always @(posedge clk) begin
		prevRd <= rdN;
		cnt <= strobe ? cnt + 8'h1 : 8'h0;
		if (aleOut)
			lat <= {addrOut[23:16] & addrOe[23:16], adBusOut};
		else if (rdN && wrN && addrOe[0])
			lat <= addrOut & addrOe;
		// Released bus toggles so stale data never looks valid
		if (!rdN && csN != 5'h1f)
			adBusIn <= lat[15:0] ^ 16'ha5c3;
		else
			adBusIn <= ~adBusIn;
		if (!rdN && prevRd) begin
			lastOe <= addrOe;
			lastCs <= csN;
		end
		if (!wrN)
			wrData <= adBusOut;
		ipbAck <= ipbReq && !ipbAck;
		ipbRdata <= (ipbReq && !ipbAck) ? ipbAddr[15:0] ^ 16'h3c3c :
			~ipbRdata;
	end
endmodule

`default_nettype wire

/* File: test/ext_bus_ctrl_bench.sv */
/*
 * Self-checking bench for the external bus controller.
 * Assumes the design files and the memory model are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none

module ext_bus_ctrl_bench;
	logic clk, reset, reqValid, reqWrite, reqWord, singleChip;
	logic readyActiveHigh, reqReady, rspValid, rspError, bus_ref_clock_out;
	logic adBusOe, aleOut, rdN, wrN, ipbReq, ipbWrite, ipbAck, readyPin, er;
	logic [23:0] reqAddr, addrOut, addrOe, ipbAddr, lastOe;
	logic [15:0] reqWdata, rspRdata, adBusOut, adBusIn, ipbWdata;
	logic [15:0] ipbRdata, wrData, rd, e;
	logic [4:0] addrWidth, csN, lastCs;
	logic [2:0] segLines;
	logic [3:0] windowEnable;
	logic [7:0] rdyDelay;
	logic wordMode = 1'b1;
	logic [63:0] window_select_cfg;
	logic [19:0] region_timing_cfg, region_function_cfg;
	logic [23:0] wa [5] = '{24'h012000, 24'h018010, 24'h041000,
		24'h044020, 24'h060000};
	logic [4:0] wcs [5] = '{5'h1d, 5'h1b, 5'h17, 5'h0f, 5'h1e};
	logic [4:0] awv [4] = '{5'h10, 5'h14, 5'h18, 5'h18};
	logic [2:0] sgv [4] = '{3'h0, 3'h7, 3'h7, 3'h2};
	logic [23:0] oev [4] = '{24'h00ffff, 24'h0fffff, 24'h7fffff,
		24'h03ffff};
	int errTotal, checksDone, cyc, lat;

	ext_bus_ctrl dut_u (.clk, .reset, .reqValid, .reqReady, .reqAddr,
		.reqWrite, .reqWord, .reqWdata, .rspValid, .rspError, .rspRdata,
		.singleChip, .addrWidth, .segLines, .readyActiveHigh, .windowEnable,
		.window_select_cfg, .region_timing_cfg, .region_function_cfg,
		.bus_ref_clock_out, .addrOut, .addrOe, .adBusOut, .adBusOe, .adBusIn,
		.aleOut, .rdN, .wrN, .csN, .readyPin, .ipbReq, .ipbWrite, .ipbAddr,
		.ipbWdata, .ipbAck, .ipbRdata);

	ext_mem_model mem_u (.clk, .readyActiveHigh, .rdyDelay, .addrOut,
		.addrOe, .adBusOut, .aleOut, .rdN, .wrN, .csN, .ipbReq, .ipbAddr,
		.adBusIn, .readyPin, .ipbAck, .ipbRdata, .lastOe, .lastCs, .wrData);

	// ****************
	// Helpers
	// ****************
	function automatic logic [15:0] mf(input logic [23:0] a);
		return a[15:0] ^ 16'ha5c3;
	endfunction

	task check(input logic [23:0] seen, input logic [23:0] exp);
		checksDone++;
		if (seen !== exp) begin
			errTotal++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task giveVerdict();
		$display("checks %0d mismatches %0d", checksDone, errTotal);
		if (errTotal == 0 && checksDone > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// One request, entered just after an edge
	task access(input logic [23:0] a, input logic w, input logic [15:0] d);
		reqAddr = a;
		reqWrite = w;
		reqWord = wordMode;
		reqWdata = d;
		reqValid = 1'b1;
		while (!reqReady) @(posedge clk) #1;
		@(posedge clk) #1;
		reqValid = 1'b0;
		lat = 1;
		while (!rspValid && lat < 2000) begin
			@(posedge clk) #1;
			lat++;
		end
		if (!rspValid)
			errTotal++;
		rd = rspRdata;
		er = rspError;
	endtask

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			errTotal++;
			giveVerdict();
		end
	end

	// ****************
	// Tests
	// ****************
	initial begin
		reset = 1'b1;
		reqValid = 1'b0;
		reqAddr = 24'h0;
		reqWrite = 1'b0;
		reqWord = 1'b0;
		reqWdata = 16'h0;
		singleChip = 1'b0;
		addrWidth = 5'h18;
		segLines = 3'h7;
		readyActiveHigh = 1'b1;
		windowEnable = 4'hf;
		rdyDelay = 8'h0;
		window_select_cfg = 64'h0440_0404_0180_0104;
		region_timing_cfg = 20'h02000;
		region_function_cfg = 20'h9db89;
		repeat (4) @(posedge clk);
		#1 reset = 1'b0;
		check({reqReady, rdN, wrN, csN}, 8'hff);
		$display("test reset done");
		for (int i = 0; i < 5; i++) begin
			access(wa[i], 1'b0, 16'h0);
			e = (i == 0) ? (mf(wa[i] + 24'h1) << 8) | (mf(wa[i]) & 16'h00ff)
				: mf(wa[i]);
			check(lastCs, wcs[i]);
			check(rd, e);
		end
		$display("test windows done");
		access(24'h060004, 1'b1, 16'hbeef);
		check(wrData, 16'hbeef);
		access(24'h012002, 1'b1, 16'h1234);
		check(wrData[7:0], 8'h12);
		wordMode = 1'b0;
		access(24'h012000, 1'b0, 16'h0);
		check(rd, mf(24'h012000) & 16'h00ff);
		wordMode = 1'b1;
		$display("test writes done");
		rdyDelay = 8'h28;
		readyActiveHigh = 1'b0;
		access(24'h041000, 1'b0, 16'h0);
		check(lat > 40, 1'b1);
		check(rd, mf(24'h041000));
		access(24'h060000, 1'b0, 16'h0);
		check(lat < 40, 1'b1);
		rdyDelay = 8'h0;
		readyActiveHigh = 1'b1;
		$display("test ready done");
		for (int i = 0; i < 4; i++) begin
			addrWidth = awv[i];
			segLines = sgv[i];
			access(24'h060000, 1'b0, 16'h0);
			check(lastOe, oev[i]);
		end
		addrWidth = 5'h18;
		segLines = 3'h7;
		$display("test width done");
		singleChip = 1'b1;
		access(24'h060000, 1'b0, 16'h0);
		check(er, 1'b1);
		access(24'h200100, 1'b1, 16'h5555);
		check(er, 1'b0);
		access(24'h200102, 1'b0, 16'h0);
		check(rd, 16'h0102 ^ 16'h3c3c);
		singleChip = 1'b0;
		$display("test chip done");
		giveVerdict();
	end
endmodule

`default_nettype wire
